// File: verilog/byte_rotate_unit.sv
// Overview of operation
// [RULE_01] Left rotate copy: bit 7 wraps to bit 0, result to working register only.
// [RULE_02] Left rotate through flag in place: flag into bit 0, bit 7 into flag.
// [RULE_03] Left through flag, result to working register; flag gets bit 7; memory kept.
// [RULE_04] Right rotate in place: bit 0 wraps to bit 7, flags untouched.
// [RULE_05] Right rotate copy: bit 0 wraps to bit 7, working register only.
// [RULE_06] Right through flag in place: flag into bit 7, bit 0 into flag.
module byte_rotate_unit (
	// Clock, reset and enable.
	input  wire logic                   core_clk_in,
	input  wire logic                   rst_b_in,
	input  wire logic                   clk_en_in,
	// Request from the instruction decoder.
	input  wire logic                   op_valid_in,
	input  wire rotate_pkg::rot_op_t    op_in,
	input  wire logic [7:0]             mem_rdata_in,
	input  wire logic                   flag_in,
	// Data memory write-back.
	output logic                        mem_we_out,
	output logic      [7:0]             mem_wdata_out,
	// Working register write.
	output logic                        work_we_out,
	output logic      [7:0]             work_data_out,
	// Shift-out flag update.
	output logic                        flag_we_out,
	output logic                        flag_out
);

	import rotate_pkg::*;

	typedef enum logic [1:0] {
		DEST_NONE,
		DEST_MEM,
		DEST_WORK
	} dest_t;

	logic       dir_right;
	logic       thru_flag;
	dest_t      dest;
	logic [7:0] rot_result;
	logic       rot_out_bit;

	logic       mem_we_q,   mem_we_d;
	logic [7:0] mem_data_q, mem_data_d;
	logic       work_we_q,  work_we_d;
	logic [7:0] work_q,     work_d;
	logic       flag_we_q,  flag_we_d;
	logic       flag_q,     flag_d;

	// Decode each operation into direction, carry use and destination.
	always_comb begin
		dir_right = 1'b0;
		thru_flag = 1'b0;
		dest      = DEST_NONE;
		case (op_in)
			OP_ROTATE_LEFT_COPY: begin
				dest = DEST_WORK; // [RULE_01]
			end
			OP_ROTATE_LEFT_THRU_FLAG: begin
				thru_flag = 1'b1;
				dest      = DEST_MEM; // [RULE_02]
			end
			OP_ROTATE_LEFT_THRU_FLAG_COPY: begin
				thru_flag = 1'b1;
				dest      = DEST_WORK; // [RULE_03]
			end
			OP_ROTATE_RIGHT_INPLACE: begin
				dir_right = 1'b1;
				dest      = DEST_MEM; // [RULE_04]
			end
			OP_ROTATE_RIGHT_COPY: begin
				dir_right = 1'b1;
				dest      = DEST_WORK; // [RULE_05]
			end
			OP_ROTATE_RIGHT_THRU_FLAG: begin
				dir_right = 1'b1;
				thru_flag = 1'b1;
				dest      = DEST_MEM; // [RULE_06]
			end
			default: begin
				dest = DEST_NONE;
			end
		endcase
	end

	rotate_core u_rotate_core (
		.operand_in          (mem_rdata_in),
		.dir_right_in        (dir_right),
		.thru_flag_in        (thru_flag),
		.flag_in             (flag_in),
		.result_out          (rot_result),
		.shifted_out_bit_out (rot_out_bit)
	);

	// Next results. Data registers hold their last value when no write is
	// issued, so a consumer that samples late still sees stable data.
	always_comb begin
		mem_we_d   = 1'b0;
		work_we_d  = 1'b0;
		flag_we_d  = 1'b0;
		mem_data_d = mem_data_q;
		work_d     = work_q;
		flag_d     = flag_q;
		if (op_valid_in) begin
			if (dest == DEST_MEM) begin
				mem_we_d   = 1'b1; // [RULE_02] [RULE_04] [RULE_06]
				mem_data_d = rot_result;
			end
			if (dest == DEST_WORK) begin
				work_we_d = 1'b1; // [RULE_01] [RULE_03] [RULE_05]
				work_d    = rot_result;
			end
			// Only carry-through forms touch the flag; plain rotates leave it alone.
			if (thru_flag) begin
				flag_we_d = 1'b1; // [RULE_02] [RULE_03] [RULE_06]
				flag_d    = rot_out_bit;
			end
		end
	end

	// Result registers; the clock enable freezes everything.
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mem_we_q   <= 1'b0;
			mem_data_q <= MEM_DATA_RST;
			work_we_q  <= 1'b0;
			work_q     <= WORK_RST;
			flag_we_q  <= 1'b0;
			flag_q     <= FLAG_RST;
		end else if (clk_en_in) begin
			mem_we_q   <= mem_we_d;
			mem_data_q <= mem_data_d;
			work_we_q  <= work_we_d;
			work_q     <= work_d;
			flag_we_q  <= flag_we_d;
			flag_q     <= flag_d;
		end
	end

	assign mem_we_out    = mem_we_q;
	assign mem_wdata_out = mem_data_q;
	assign work_we_out   = work_we_q;
	assign work_data_out = work_q;
	assign flag_we_out   = flag_we_q;
	assign flag_out      = flag_q;

	// Checks: each operation's result, one enabled cycle later.
	property p_left_copy;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		(clk_en_in && op_valid_in && op_in == OP_ROTATE_LEFT_COPY)
		|=> (work_we_out && !mem_we_out && !flag_we_out
		&& work_data_out == {$past(mem_rdata_in[6:0]), $past(mem_rdata_in[7])});
	endproperty
	a_left_copy: assert property (p_left_copy) else $error("left copy wrong"); // [RULE_01]

	property p_left_thru;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		(clk_en_in && op_valid_in && op_in == OP_ROTATE_LEFT_THRU_FLAG)
		|=> (mem_we_out && !work_we_out && flag_we_out
		&& mem_wdata_out == {$past(mem_rdata_in[6:0]), $past(flag_in)}
		&& flag_out == $past(mem_rdata_in[7]));
	endproperty
	a_left_thru: assert property (p_left_thru) else $error("left thru flag wrong"); // [RULE_02]

	property p_left_thru_copy;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		(clk_en_in && op_valid_in && op_in == OP_ROTATE_LEFT_THRU_FLAG_COPY)
		|=> (work_we_out && !mem_we_out && flag_we_out
		&& work_data_out == {$past(mem_rdata_in[6:0]), $past(flag_in)}
		&& flag_out == $past(mem_rdata_in[7]));
	endproperty
	a_left_thru_copy: assert property (p_left_thru_copy) else $error("left thru copy wrong"); // [RULE_03]

	property p_right_inplace;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		(clk_en_in && op_valid_in && op_in == OP_ROTATE_RIGHT_INPLACE)
		|=> (mem_we_out && !work_we_out && !flag_we_out
		&& mem_wdata_out == {$past(mem_rdata_in[0]), $past(mem_rdata_in[7:1])});
	endproperty
	a_right_inplace: assert property (p_right_inplace) else $error("right rotate wrong"); // [RULE_04]

	property p_right_copy;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		(clk_en_in && op_valid_in && op_in == OP_ROTATE_RIGHT_COPY)
		|=> (work_we_out && !mem_we_out && !flag_we_out
		&& work_data_out == {$past(mem_rdata_in[0]), $past(mem_rdata_in[7:1])});
	endproperty
	a_right_copy: assert property (p_right_copy) else $error("right copy wrong"); // [RULE_05]

	property p_right_thru;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		(clk_en_in && op_valid_in && op_in == OP_ROTATE_RIGHT_THRU_FLAG)
		|=> (mem_we_out && !work_we_out && flag_we_out
		&& mem_wdata_out == {$past(flag_in), $past(mem_rdata_in[7:1])}
		&& flag_out == $past(mem_rdata_in[0]));
	endproperty
	a_right_thru: assert property (p_right_thru) else $error("right thru flag wrong"); // [RULE_06]

	// The flag value may only move together with its write strobe, so plain
	// rotates can never disturb the shift-out flag.
	property p_flag_stable;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		$changed(flag_out) |-> flag_we_out;
	endproperty
	a_flag_stable: assert property (p_flag_stable) else $error("flag moved without write"); // [RULE_04]

	property p_freeze;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		!clk_en_in |=> ($stable(work_data_out) && $stable(mem_wdata_out) && $stable(flag_out)
		&& $stable(mem_we_out) && $stable(work_we_out) && $stable(flag_we_out));
	endproperty
	a_freeze: assert property (p_freeze) else $error("state changed while disabled"); // [RULE_05]

	// Without a rotate request an enabled edge must leave every strobe low.
	property p_no_op;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		(clk_en_in && (!op_valid_in || op_in == OP_NONE))
		|=> (!mem_we_out && !work_we_out && !flag_we_out);
	endproperty
	a_no_op: assert property (p_no_op) else $error("write strobe without request");

	c_mem_write: cover property (@(posedge core_clk_in) disable iff (!rst_b_in) mem_we_out);
	c_work_write: cover property (@(posedge core_clk_in) disable iff (!rst_b_in) work_we_out);
	c_flag_set: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
		flag_we_out && flag_out);
	c_right_thru: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && op_valid_in && op_in == OP_ROTATE_RIGHT_THRU_FLAG);

endmodule

// File: verilog/rotate_pkg.sv
package rotate_pkg;

	// Operation select codes presented by the instruction decoder.
	typedef enum logic [2:0] {
		OP_NONE,
		OP_ROTATE_LEFT_COPY,
		OP_ROTATE_LEFT_THRU_FLAG,
		OP_ROTATE_LEFT_THRU_FLAG_COPY,
		OP_ROTATE_RIGHT_INPLACE,
		OP_ROTATE_RIGHT_COPY,
		OP_ROTATE_RIGHT_THRU_FLAG
	} rot_op_t;

	// Width of a data memory byte and of the working register.
	localparam int          DATA_W          = 8;
	// Bit positions that cross the byte boundary during a rotation.
	localparam int          MSB_POS         = 7;
	localparam int          LSB_POS         = 0;
	// Reset values of the result registers.
	localparam logic [7:0]  WORK_RST        = 8'h00;
	localparam logic [7:0]  MEM_DATA_RST    = 8'h00;
	localparam logic        FLAG_RST        = 1'b0;
	// Cycles from an accepted request to its registered result.
	localparam int          RESULT_LATENCY  = 1;

endpackage

// File: verilog/rotate_core.sv
// Pure combinational rotator: one position left or right, with an
// optional carry-in that replaces the wrapped bit.
module rotate_core (
	// Operand and control.
	input  wire logic [7:0] operand_in,
	input  wire logic       dir_right_in,
	input  wire logic       thru_flag_in,
	input  wire logic       flag_in,
	// Result.
	output logic      [7:0] result_out,
	output logic            shifted_out_bit_out
);

	import rotate_pkg::*;

	logic fill_bit;

	// The bit that leaves the byte either wraps round or is swapped with the flag.
	always_comb begin
		shifted_out_bit_out = dir_right_in ? operand_in[LSB_POS] : operand_in[MSB_POS];
		fill_bit            = thru_flag_in ? flag_in : shifted_out_bit_out;
		if (dir_right_in) begin
			result_out = {fill_bit, operand_in[MSB_POS:1]};
		end else begin
			result_out = {operand_in[MSB_POS-1:LSB_POS], fill_bit};
		end
	end

endmodule

// File: verif/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import rotate_pkg::*;

	logic       core_clk_in = 1'b0;
	logic       rst_b_in = 1'b0;
	logic       clk_en_in = 1'b1;
	logic       op_valid_in = 1'b0;
	logic       flag_in = 1'b0;
	rot_op_t    op_in = OP_NONE;
	logic [7:0] mem_rdata_in = 8'h00;
	logic       mem_we_out;
	logic       work_we_out;
	logic       flag_we_out;
	logic       flag_out;
	logic [7:0] mem_wdata_out;
	logic [7:0] work_data_out;
	int         err_count = 0;
	int         checks_done = 0;

	// A 40 ns period gives the 25 MHz core clock.
	always #20 core_clk_in = ~core_clk_in;

	byte_rotate_unit dut_u (
		.core_clk_in   (core_clk_in),
		.rst_b_in      (rst_b_in),
		.clk_en_in     (clk_en_in),
		.op_valid_in   (op_valid_in),
		.op_in         (op_in),
		.mem_rdata_in  (mem_rdata_in),
		.flag_in       (flag_in),
		.mem_we_out    (mem_we_out),
		.mem_wdata_out (mem_wdata_out),
		.work_we_out   (work_we_out),
		.work_data_out (work_data_out),
		.flag_we_out   (flag_we_out),
		.flag_out      (flag_out)
	);

	// Compare tasks use case equality so an unknown never counts as a match.
	task automatic cmp1(input logic got, input logic exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
		end
	endtask

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic strobes(input logic mw, input logic ww, input logic fw);
		cmp1(mem_we_out, mw, "mem_we");
		cmp1(work_we_out, ww, "work_we");
		cmp1(flag_we_out, fw, "flag_we");
	endtask

	// Called at a falling edge; drives a request and waits one full cycle, so the
	// registered answer is settled when the caller looks at it.
	task automatic send(input rot_op_t op, input logic [7:0] m, input logic f);
		op_valid_in = 1'b1;
		op_in = op;
		mem_rdata_in = m;
		flag_in = f;
		@(negedge core_clk_in);
	endtask

	task automatic idle();
		op_valid_in = 1'b0;
		op_in = OP_NONE;
		@(negedge core_clk_in);
	endtask

	task automatic t_left_copy();
		send(OP_ROTATE_LEFT_COPY, 8'hC0, 1'b0);
		strobes(1'b0, 1'b1, 1'b0);
		cmp8(work_data_out, 8'h81, "left copy");
		idle();
		$display("left copy test done");
	endtask

	// Two requests back to back, the second fed with the updated flag.
	task automatic t_left_thru();
		send(OP_ROTATE_LEFT_THRU_FLAG, 8'h81, 1'b0);
		strobes(1'b1, 1'b0, 1'b1);
		cmp8(mem_wdata_out, 8'h02, "left thru");
		cmp1(flag_out, 1'b1, "left thru flag");
		send(OP_ROTATE_LEFT_THRU_FLAG, 8'h40, 1'b1);
		cmp8(mem_wdata_out, 8'h81, "left thru 2");
		cmp1(flag_out, 1'b0, "left thru flag 2");
		idle();
		$display("left through flag test done");
	endtask

	task automatic t_left_thru_copy();
		send(OP_ROTATE_LEFT_THRU_FLAG_COPY, 8'h7F, 1'b1);
		strobes(1'b0, 1'b1, 1'b1);
		cmp8(work_data_out, 8'hFF, "left thru copy");
		cmp1(flag_out, 1'b0, "left thru copy flag");
		idle();
		$display("left through flag copy test done");
	endtask

	task automatic t_right_inplace();
		send(OP_ROTATE_RIGHT_INPLACE, 8'h01, 1'b0);
		strobes(1'b1, 1'b0, 1'b0);
		cmp8(mem_wdata_out, 8'h80, "right inplace");
		idle();
		$display("right in place test done");
	endtask

	// The flag is set here so that a flag leaking into bit 7 would show.
	task automatic t_right_copy();
		send(OP_ROTATE_RIGHT_COPY, 8'h02, 1'b1);
		strobes(1'b0, 1'b1, 1'b0);
		cmp8(work_data_out, 8'h01, "right copy");
		idle();
		$display("right copy test done");
	endtask

	task automatic t_right_thru();
		send(OP_ROTATE_RIGHT_THRU_FLAG, 8'h01, 1'b1);
		strobes(1'b1, 1'b0, 1'b1);
		cmp8(mem_wdata_out, 8'h80, "right thru");
		cmp1(flag_out, 1'b1, "right thru flag");
		send(OP_ROTATE_RIGHT_THRU_FLAG, 8'hFE, 1'b0);
		cmp8(mem_wdata_out, 8'h7F, "right thru 2");
		cmp1(flag_out, 1'b0, "right thru flag 2");
		idle();
		$display("right through flag test done");
	endtask

	// No-op and a frozen clock enable must produce no strobes at all.
	task automatic t_none_and_freeze();
		send(OP_NONE, 8'hAA, 1'b1);
		strobes(1'b0, 1'b0, 1'b0);
		cmp8(mem_wdata_out, 8'h7F, "held mem data");
		clk_en_in = 1'b0;
		send(OP_ROTATE_RIGHT_COPY, 8'h10, 1'b0);
		strobes(1'b0, 1'b0, 1'b0);
		cmp8(work_data_out, 8'h01, "frozen work data");
		clk_en_in = 1'b1;
		@(negedge core_clk_in);
		strobes(1'b0, 1'b1, 1'b0);
		cmp8(work_data_out, 8'h08, "after enable");
		idle();
		strobes(1'b0, 1'b0, 1'b0);
		$display("no-op and enable test done");
	endtask

	// A reset in mid-run clears every output at once; the first edge after
	// release may already carry a request.
	task automatic t_mid_reset();
		send(OP_ROTATE_LEFT_THRU_FLAG, 8'h80, 1'b0);
		cmp1(flag_out, 1'b1, "flag before reset");
		rst_b_in = 1'b0;
		op_valid_in = 1'b0;
		op_in = OP_NONE;
		@(negedge core_clk_in);
		strobes(1'b0, 1'b0, 1'b0);
		cmp8(mem_wdata_out, MEM_DATA_RST, "mem data in reset");
		cmp8(work_data_out, WORK_RST, "work data in reset");
		cmp1(flag_out, FLAG_RST, "flag in reset");
		rst_b_in = 1'b1;
		send(OP_ROTATE_RIGHT_COPY, 8'h03, 1'b0);
		strobes(1'b0, 1'b1, 1'b0);
		cmp8(work_data_out, 8'h81, "right copy after reset");
		idle();
		$display("mid-run reset test done");
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// The tests need well under 100 cycles; this limit leaves a wide margin.
	initial begin
		#20000;
		err_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		close_out();
	end

	initial begin
		repeat (6) @(negedge core_clk_in);
		strobes(1'b0, 1'b0, 1'b0);
		rst_b_in = 1'b1;
		t_left_copy();
		t_left_thru();
		t_left_thru_copy();
		t_right_inplace();
		t_right_copy();
		t_right_thru();
		t_none_and_freeze();
		t_mid_reset();
		close_out();
	end
endmodule
